//--- verilog/ormove_decode.sv
// decode and execute of or, copy, load-pointer and memory move
// assumes fetch offers words in phase one and a data memory whose
// read data follow one clock after the read strobe
`timescale 1ns/1ps

module ormove_decode
#(
    parameter logic [7:0] ACCESS_SPLIT = 8'h80,
    parameter int INDEX_PTR = 2,
    parameter logic [11:0] PC_LOW_ADDR = 12'hff0,
    parameter logic [11:0] STACK_UPPER_ADDR = 12'hff1,
    parameter logic [11:0] STACK_HIGH_ADDR = 12'hff2,
    parameter logic [11:0] STACK_LOW_ADDR = 12'hff3
)
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] instr_word_i,
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    output logic [11:0] dmem_addr_o,
    output logic dmem_rd_o,
    output logic dmem_wr_o,
    output logic [7:0] dmem_wdata_o,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import ormove_pkg::*;

    typedef struct packed {
        seq_e seq;
        op_e op;
        logic [15:0] word;
        logic [7:0] acc;
        logic [3:0] bank;
        logic [2:0][11:0] ptr;
        logic neg;
        logic zero;
        logic ext_en;
        logic [7:0] data;
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic bad_dest;
        logic bad_word;
        logic ack;
        logic [31:0] rdata;
    } state_s;

    localparam state_s ST_RST = '{
        seq: SEQ_FIRST, op: OP_NONE, word: 16'h0000, acc: ACCUM_RST,
        bank: BANK_RST, ptr: {3{PTR_RST}}, neg: 1'b0, zero: 1'b0,
        ext_en: 1'b0, data: 8'h00, addr: 12'h000, rd: 1'b0, wr: 1'b0,
        wdata: 8'h00, bad_dest: 1'b0, bad_word: 1'b0, ack: 1'b0,
        rdata: 32'h0000_0000};

    state_s st_reg;
    state_s st_next;
    logic take;
    logic dec_file;
    logic [11:0] eff_addr;
    logic forbid;
    logic [7:0] fld;

    phase_if ph();

    phase_gen u_phase
    (
        .mclk_i (mclk_i),
        .rst_n_i (rst_n_i),
        .ph (ph.gen)
    );

    assign instr_ready_o = ph.q1;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
    assign avs_readdata_o = st_reg.rdata;
    assign dmem_addr_o = st_reg.addr;
    assign dmem_rd_o = st_reg.rd;
    assign dmem_wr_o = st_reg.wr;
    assign dmem_wdata_o = st_reg.wdata;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.rd = 1'b0;
        st_next.wr = 1'b0;
        st_next.ack = 1'b0;
        take = ph.q1 & instr_valid_i;
        fld = instr_word_i[7:0];
        dec_file = (instr_word_i[15:10] == OPC_OR) ||
            (instr_word_i[15:10] == OPC_COPY);
        forbid = (st_reg.addr == PC_LOW_ADDR) ||
            (st_reg.addr == STACK_UPPER_ADDR) ||
            (st_reg.addr == STACK_HIGH_ADDR) ||
            (st_reg.addr == STACK_LOW_ADDR);

        // address of the file operand
        if (instr_word_i[ACCESS_BIT])
            eff_addr = {st_reg.bank, fld};
        else if (st_reg.ext_en && fld <= INDEX_MAX)
            eff_addr = st_reg.ptr[INDEX_PTR] + {4'h0, fld};
        else if (fld < ACCESS_SPLIT)
            eff_addr = {ACCESS_LOW_PAGE, fld};
        else
            eff_addr = {ACCESS_HIGH_PAGE, fld};

        // register bus, one wait cycle per access
        if ((avs_read_i || avs_write_i) && !st_reg.ack)
        begin
            st_next.ack = 1'b1;
            st_next.rdata = 32'h0000_0000;
            case (avs_address_i)
                CTRL_OFS: st_next.rdata[CTRL_EXT_BIT] = st_reg.ext_en;
                ACCUM_OFS: st_next.rdata[7:0] = st_reg.acc;
                BANK_OFS: st_next.rdata[3:0] = st_reg.bank;
                STATUS_OFS:
                begin
                    st_next.rdata[ST_ZERO_BIT] = st_reg.zero;
                    st_next.rdata[ST_NEG_BIT] = st_reg.neg;
                    st_next.rdata[ST_BAD_DEST_BIT] = st_reg.bad_dest;
                    st_next.rdata[ST_BAD_WORD_BIT] = st_reg.bad_word;
                    st_next.rdata[ST_BUSY_BIT] =
                        (st_reg.op != OP_NONE);
                end
                PTR0_OFS: st_next.rdata[11:0] = st_reg.ptr[0];
                PTR1_OFS: st_next.rdata[11:0] = st_reg.ptr[1];
                PTR2_OFS: st_next.rdata[11:0] = st_reg.ptr[2];
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end

        // write lands only in the cycle waitrequest is low
        if (avs_write_i && st_reg.ack && avs_byteenable_i[0])
        begin
            case (avs_address_i)
                CTRL_OFS: st_next.ext_en = avs_writedata_i[CTRL_EXT_BIT];
                ACCUM_OFS: st_next.acc = avs_writedata_i[7:0];
                BANK_OFS: st_next.bank = avs_writedata_i[3:0];
                STATUS_OFS:
                begin
                    if (avs_writedata_i[ST_BAD_DEST_BIT])
                        st_next.bad_dest = 1'b0;
                    if (avs_writedata_i[ST_BAD_WORD_BIT])
                        st_next.bad_word = 1'b0;
                end
                default: st_next.acc = st_next.acc;
            endcase
        end

        // phase one: decode or take the second word
        if (take)
        begin
            case (st_reg.seq)
                SEQ_FIRST:
                begin
                    st_next.word = instr_word_i;
                    st_next.op = OP_NONE;
                    if (dec_file)
                    begin
                        st_next.op = (instr_word_i[15:10] == OPC_OR) ?
                            OP_OR : OP_COPY;
                        st_next.addr = eff_addr;
                        st_next.rd = 1'b1;
                    end
                    else if (instr_word_i[15:8] == OPC_PTR &&
                        instr_word_i[7:6] == OPC_PTR_PAD &&
                        instr_word_i[5:4] != 2'b11)
                    begin
                        st_next.op = OP_PTR;
                        st_next.seq = SEQ_PTR2;
                    end
                    else if (instr_word_i[15:12] == OPC_MOVE)
                    begin
                        st_next.op = OP_MOVE;
                        st_next.seq = SEQ_MOVE2;
                        st_next.addr = instr_word_i[11:0];
                        st_next.rd = 1'b1;
                    end
                end
                SEQ_PTR2:
                begin
                    st_next.seq = SEQ_FIRST;
                    if (instr_word_i[15:8] == OPC_PTR2)
                        st_next.data = instr_word_i[7:0];
                    else
                    begin
                        st_next.op = OP_NONE;
                        st_next.bad_word = 1'b1;
                    end
                end
                SEQ_MOVE2:
                begin
                    st_next.seq = SEQ_FIRST;
                    if (instr_word_i[15:12] == OPC_MOVE2)
                        st_next.addr = instr_word_i[11:0];
                    else
                    begin
                        st_next.op = OP_NONE;
                        st_next.bad_word = 1'b1;
                    end
                end
                default: st_next.seq = SEQ_FIRST;
            endcase
        end

        // phase three: process read data
        if (ph.q3 && st_reg.seq != SEQ_PTR2)
        begin
            case (st_reg.op)
                OP_OR, OP_COPY:
                begin
                    st_next.data = (st_reg.op == OP_OR) ?
                        (st_reg.acc | dmem_rdata_i) : dmem_rdata_i;
                    st_next.neg = st_next.data[7];
                    st_next.zero = (st_next.data == 8'h00);
                end
                OP_MOVE:
                    if (st_reg.seq == SEQ_MOVE2)
                        st_next.data = dmem_rdata_i;
                default: st_next.data = st_reg.data;
            endcase
        end

        // phase four: write the destination
        if (ph.q4)
        begin
            case (st_reg.op)
                OP_OR, OP_COPY:
                begin
                    if (st_reg.word[DEST_BIT])
                    begin
                        st_next.wr = 1'b1;
                        st_next.wdata = st_reg.data;
                    end
                    else
                        st_next.acc = st_reg.data;
                end
                OP_PTR:
                    if (st_reg.seq == SEQ_PTR2)
                        st_next.ptr[st_reg.word[5:4]][11:8] =
                            st_reg.word[3:0];
                    else
                        st_next.ptr[st_reg.word[5:4]][7:0] =
                            st_reg.data;
                OP_MOVE:
                    if (st_reg.seq == SEQ_FIRST)
                    begin
                        if (forbid)
                            st_next.bad_dest = 1'b1;
                        else
                        begin
                            st_next.wr = 1'b1;
                            st_next.wdata = st_reg.data;
                        end
                    end
                default: st_next.op = OP_NONE;
            endcase
            if (st_reg.seq == SEQ_FIRST)
                st_next.op = OP_NONE;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_or_acc;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q3 && st_reg.op == OP_OR && !st_reg.word[DEST_BIT] &&
            st_reg.seq == SEQ_FIRST) |-> ##2
        (st_reg.acc == ($past(st_reg.acc, 2) | $past(dmem_rdata_i, 2)));
    endproperty
    a_or_acc: assert property (p_or_acc)
        else $error("or result not in accumulator");

    property p_dest_file;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q4 && (st_reg.op == OP_OR || st_reg.op == OP_COPY) &&
            st_reg.word[DEST_BIT]) |=>
        (dmem_wr_o && dmem_wdata_o == $past(st_reg.data) &&
            st_reg.acc == $past(st_reg.acc));
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file destination not written");

    property p_access_bank;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (take && st_reg.seq == SEQ_FIRST && dec_file &&
            !instr_word_i[ACCESS_BIT] && !st_reg.ext_en) |=>
        (dmem_rd_o && (dmem_addr_o[11:8] == ACCESS_LOW_PAGE ||
            dmem_addr_o[11:8] == ACCESS_HIGH_PAGE));
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("access bank address wrong");

    property p_bank_sel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (take && st_reg.seq == SEQ_FIRST && dec_file &&
            instr_word_i[ACCESS_BIT]) |=>
        (dmem_addr_o == {$past(st_reg.bank), $past(instr_word_i[7:0])});
    endproperty
    a_bank_sel: assert property (p_bank_sel)
        else $error("banked address wrong");

    property p_indexed;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (take && st_reg.seq == SEQ_FIRST && dec_file &&
            !instr_word_i[ACCESS_BIT] && st_reg.ext_en &&
            instr_word_i[7:0] <= INDEX_MAX) |=>
        (dmem_addr_o == $past(st_reg.ptr[INDEX_PTR] +
            {4'h0, instr_word_i[7:0]}));
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");

    property p_copy_flags;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q3 && st_reg.op == OP_COPY) |=>
        (st_reg.zero == ($past(dmem_rdata_i) == 8'h00) &&
            st_reg.neg == $past(dmem_rdata_i[7]));
    endproperty
    a_copy_flags: assert property (p_copy_flags)
        else $error("copy flags wrong");

    property p_ptr_low;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q4 && st_reg.op == OP_PTR && st_reg.seq == SEQ_FIRST) |=>
        (st_reg.ptr[$past(st_reg.word[5:4])][7:0] == $past(st_reg.data)
            && st_reg.zero == $past(st_reg.zero, 4) &&
            st_reg.neg == $past(st_reg.neg, 4));
    endproperty
    a_ptr_low: assert property (p_ptr_low)
        else $error("pointer low byte wrong");

    property p_ptr_high;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q4 && st_reg.op == OP_PTR && st_reg.seq == SEQ_PTR2) |=>
        (st_reg.ptr[$past(st_reg.word[5:4])][11:8] ==
            $past(st_reg.word[3:0]));
    endproperty
    a_ptr_high: assert property (p_ptr_high)
        else $error("pointer high byte wrong");

    property p_move_write;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ph.q4 && st_reg.op == OP_MOVE && st_reg.seq == SEQ_FIRST) |=>
        ($past(forbid) ? (!dmem_wr_o && st_reg.bad_dest) :
            (dmem_wr_o && dmem_addr_o == $past(st_reg.addr) &&
            dmem_wdata_o == $past(st_reg.data) &&
            st_reg.zero == $past(st_reg.zero)));
    endproperty
    a_move_write: assert property (p_move_write)
        else $error("memory move write wrong");

    property p_one_cycle;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (take && st_reg.seq == SEQ_FIRST && dec_file) |->
        ##1 (st_reg.op != OP_NONE)[*3] ##1 (st_reg.op == OP_NONE);
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("or or copy not done in one cycle");

    property p_move_span;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (take && st_reg.seq == SEQ_FIRST &&
            instr_word_i[15:12] == OPC_MOVE) |->
        ##1 (!dmem_wr_o)[*4] ##0 (st_reg.seq == SEQ_MOVE2);
    endproperty
    a_move_span: assert property (p_move_span)
        else $error("memory move wrote too early");
endmodule

//--- verilog/ormove_pkg.sv
// constants, types and register map of the or/move/load-pointer decoder
// assumes a 100 MHz core clock and four clock phases per instruction cycle
//
// Overview of operation
// - word 0001 00da ffffffff ors accumulator with file; sets negative, zero
// - destination bit 0 sends result to accumulator, file left unchanged
// - destination bit 1 writes result back to the addressed file
// - access bit 0 addresses the fixed access bank
// - access bit 1 takes upper address bits from the bank select register
// - access 0, extended mode, field up to 95: indexed literal offset
// - the 8-bit field reaches every byte of a 256-byte bank
// - word 0101 00da ffffffff copies file to destination; sets flags
// - load pointer puts a 12-bit literal in pointer 0..2; flags kept
// - load pointer: opcode, selector, high nibble; then 1111 0000 low byte
// - memory move copies 12-bit source to 12-bit destination; flags kept
// - memory move never writes program counter low or stack top bytes

package ormove_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] ACCUM_OFS = 5'h04;
    localparam logic [4:0] BANK_OFS = 5'h08;
    localparam logic [4:0] STATUS_OFS = 5'h0c;
    localparam logic [4:0] PTR0_OFS = 5'h10;
    localparam logic [4:0] PTR1_OFS = 5'h14;
    localparam logic [4:0] PTR2_OFS = 5'h18;

    localparam int CTRL_EXT_BIT = 0;
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_NEG_BIT = 1;
    localparam int ST_BAD_DEST_BIT = 2;
    localparam int ST_BAD_WORD_BIT = 3;
    localparam int ST_BUSY_BIT = 4;

    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [11:0] PTR_RST = 12'h000;

    // ************************************************************
    // instruction encodings
    // ************************************************************
    localparam logic [5:0] OPC_OR = 6'b000100;
    localparam logic [5:0] OPC_COPY = 6'b010100;
    localparam logic [7:0] OPC_PTR = 8'hee;
    localparam logic [1:0] OPC_PTR_PAD = 2'b00;
    localparam logic [7:0] OPC_PTR2 = 8'hf0;
    localparam logic [3:0] OPC_MOVE = 4'hc;
    localparam logic [3:0] OPC_MOVE2 = 4'hf;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam logic [7:0] INDEX_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHASES = 4;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SEQ_FIRST = 2'b00,
        SEQ_PTR2 = 2'b01,
        SEQ_MOVE2 = 2'b10
    } seq_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_OR = 3'b001,
        OP_COPY = 3'b010,
        OP_PTR = 3'b011,
        OP_MOVE = 3'b100
    } op_e;

endpackage

//--- verilog/phase_if.sv
// interface carrying the four instruction phase strobes
// assumes one driver (the phase generator) on the core clock
`timescale 1ns/1ps

interface phase_if;
    logic q1;
    logic q2;
    logic q3;
    logic q4;

    modport gen (output q1, output q2, output q3, output q4);
    modport use_ph (input q1, input q2, input q3, input q4);
endinterface

//--- verilog/phase_gen.sv
// four-phase instruction cycle generator
// assumes synchronous active-low reset on the core clock
`timescale 1ns/1ps

module phase_gen
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    phase_if.gen ph
);
    import ormove_pkg::*;

    typedef struct packed {
        logic [1:0] cnt;
    } phase_s;

    phase_s st_reg;
    phase_s st_next;

    // ************************************************************
    // phase counter
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.cnt = st_reg.cnt + 2'h1;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign ph.q1 = (st_reg.cnt == 2'h0);
    assign ph.q2 = (st_reg.cnt == 2'h1);
    assign ph.q3 = (st_reg.cnt == 2'h2);
    assign ph.q4 = (st_reg.cnt == 2'h3);
endmodule

//--- verif/fetch_mem_model.sv
// fetch unit and data memory model facing the decoder
// assumes the decoder ports on one 100 MHz core clock
`timescale 1ns/1ps

module fetch_mem_model
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic instr_ready_i,
    output logic [15:0] instr_word_o,
    output logic instr_valid_o,
    input wire logic [11:0] dmem_addr_i,
    input wire logic dmem_rd_i,
    input wire logic dmem_wr_i,
    input wire logic [7:0] dmem_wdata_i,
    output logic [7:0] dmem_rdata_o
);
    logic [7:0] mem [4096];
    logic [15:0] words [$];
    int since_take = 0;
    int wr_gap = 0;
    int wr_count = 0;

    initial
    begin
        instr_word_o = 16'h0000;
        instr_valid_o = 1'b0;
        dmem_rdata_o = 8'h5a;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    task automatic push(input logic [15:0] w);
        words.push_back(w);
    endtask

    function automatic bit idle();
        return words.size() == 0 && !instr_valid_o;
    endfunction

    // ************************************************************
    // word offer and memory port
    // ************************************************************
    always @(posedge mclk_i)
    begin
        since_take <= since_take + 1;
        // word held until taken in phase one
        if (rst_n_i && instr_ready_i && instr_valid_o)
        begin
            void'(words.pop_front());
            since_take <= 0;
        end
        instr_valid_o <= words.size() > 0;
        instr_word_o <= words.size() > 0 ? words[0] : ~instr_word_o;
        // data only in the cycle after the strobe, else scrambled
        dmem_rdata_o <= dmem_rd_i ? mem[dmem_addr_i] : ~dmem_rdata_o;
        if (dmem_wr_i)
        begin
            mem[dmem_addr_i] <= dmem_wdata_i;
            wr_gap <= since_take;
            wr_count <= wr_count + 1;
        end
    end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the or/move/load-pointer decoder
// assumes fetch_mem_model as fetch unit and data memory
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    failures++; $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end end

module tb_top;
    import ormove_pkg::*;
    localparam logic [11:0] FORBID [4] = '{12'hff0, 12'hff1, 12'hff2,
        12'hff3};
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_be = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] instr_word;
    logic instr_valid;
    logic instr_ready;
    logic [11:0] dmem_addr;
    logic dmem_rd;
    logic dmem_wr;
    logic [7:0] dmem_wdata;
    logic [7:0] dmem_rdata;
    logic [31:0] rd;
    logic [31:0] st;
    logic [11:0] k;
    int failures = 0;
    int checks = 0;

    ormove_decode #(.PC_LOW_ADDR(FORBID[0]), .STACK_UPPER_ADDR(FORBID[1]),
        .STACK_HIGH_ADDR(FORBID[2]), .STACK_LOW_ADDR(FORBID[3])) dut
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_word_i(instr_word),
        .instr_valid_i(instr_valid), .instr_ready_o(instr_ready),
        .dmem_addr_o(dmem_addr), .dmem_rd_o(dmem_rd), .dmem_wr_o(dmem_wr),
        .dmem_wdata_o(dmem_wdata), .dmem_rdata_i(dmem_rdata),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_be), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest)
    );

    fetch_mem_model partner
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_ready_i(instr_ready),
        .instr_word_o(instr_word), .instr_valid_o(instr_valid),
        .dmem_addr_i(dmem_addr), .dmem_rd_i(dmem_rd), .dmem_wr_i(dmem_wr),
        .dmem_wdata_i(dmem_wdata), .dmem_rdata_o(dmem_rdata)
    );

    always #5 mclk_i = ~mclk_i;

    // ************************************************************
    // bus and instruction helpers
    // ************************************************************
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk_i); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic settle();
        repeat (40)
            if (!partner.idle())
                @(posedge mclk_i);
        repeat (6) @(posedge mclk_i);
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("accum rst", {24'h0, ACCUM_RST}, rd)
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("status rst", 32'h0, rd)
        bus(1'b1, PTR0_OFS, 32'h123);
        bus(1'b0, PTR0_OFS, 32'h0);
        `CHK("ptr0 ro", {20'h0, PTR_RST}, rd)
        bus(1'b1, 5'h1c, 32'hff);
        bus(1'b0, 5'h1c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        avs_be <= 4'h0;
        bus(1'b1, ACCUM_OFS, 32'hff);
        avs_be <= 4'h1;
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("lane off", 32'h0, rd)
    endtask

    task automatic t_or();
        bus(1'b1, ACCUM_OFS, 32'h13);
        bus(1'b1, BANK_OFS, 32'h3);
        partner.mem[12'h391] = 8'h91;
        partner.push({OPC_OR, 1'b0, 1'b1, 8'h91});
        settle();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("or accum", 32'h93, rd)
        `CHK("or file kept", 8'h91, partner.mem[12'h391])
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("or flags", 2'b10, rd[1:0])
        bus(1'b1, ACCUM_OFS, 32'h01);
        partner.mem[12'hfa5] = 8'h40;
        partner.push({OPC_OR, 1'b1, 1'b0, 8'ha5});
        settle();
        `CHK("or file", 8'h41, partner.mem[12'hfa5])
        `CHK("or wr cycle", PHASES - 1, partner.wr_gap)
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("or accum kept", 32'h01, rd)
    endtask

    task automatic t_copy();
        int n;
        partner.push({OPC_COPY, 1'b0, 1'b0, 8'h10});
        settle();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("copy accum", 32'h0, rd)
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("copy zero", 2'b01, rd[1:0])
        bus(1'b1, BANK_OFS, 32'h5);
        partner.mem[12'h5ff] = 8'h80;
        n = partner.wr_count;
        partner.push({OPC_COPY, 1'b0, 1'b1, 8'hff});
        partner.push({OPC_COPY, 1'b1, 1'b1, 8'hff});
        settle();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("copy bank top", 32'h80, rd)
        `CHK("copy writes", n + 1, partner.wr_count)
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("copy neg", 2'b10, rd[1:0])
    endtask

    task automatic t_ptr();
        for (int s = 0; s < 3; s++)
        begin
            k = {4'(s + 1), 8'hab ^ 8'(s)};
            bus(1'b0, STATUS_OFS, 32'h0);
            st = rd;
            partner.push({OPC_PTR, OPC_PTR_PAD, 2'(s), k[11:8]});
            settle();
            bus(1'b0, PTR0_OFS + 5'(4 * s), 32'h0);
            `CHK("ptr high", {20'h0, k[11:8], 8'h00}, rd)
            partner.push({OPC_PTR2, k[7:0]});
            settle();
            bus(1'b0, PTR0_OFS + 5'(4 * s), 32'h0);
            `CHK("ptr full", {20'h0, k}, rd)
            bus(1'b0, STATUS_OFS, 32'h0);
            `CHK("ptr flags", st, rd)
        end
        partner.push({OPC_PTR, OPC_PTR_PAD, 2'b00, 4'h7});
        partner.push(16'h1234);
        settle();
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("bad word", 1'b1, rd[ST_BAD_WORD_BIT])
        bus(1'b1, STATUS_OFS, 32'h8);
    endtask

    task automatic t_indexed();
        bus(1'b1, CTRL_OFS, 32'h1);
        partner.mem[12'h3a9 + 12'h05f] = 8'h17;
        partner.mem[12'h060] = 8'h6e;
        partner.push({OPC_COPY, 1'b0, 1'b0, INDEX_MAX});
        settle();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("indexed", 32'h17, rd)
        partner.push({OPC_COPY, 1'b0, 1'b0, 8'h60});
        settle();
        bus(1'b0, ACCUM_OFS, 32'h0);
        `CHK("past index", 32'h6e, rd)
        bus(1'b1, CTRL_OFS, 32'h0);
    endtask

    task automatic t_move();
        partner.mem[12'h123] = 8'h33;
        partner.mem[12'h456] = 8'h11;
        bus(1'b0, STATUS_OFS, 32'h0);
        st = rd;
        partner.push({OPC_MOVE, 12'h123});
        partner.push({OPC_MOVE2, 12'h456});
        settle();
        `CHK("move", 8'h33, partner.mem[12'h456])
        `CHK("move wr cycle", PHASES - 1, partner.wr_gap)
        bus(1'b0, STATUS_OFS, 32'h0);
        `CHK("move flags", st, rd)
        foreach (FORBID[i])
        begin
            partner.mem[FORBID[i]] = 8'h11;
            partner.push({OPC_MOVE, 12'h123});
            partner.push({OPC_MOVE2, FORBID[i]});
            settle();
            `CHK("forbidden", 8'h11, partner.mem[FORBID[i]])
            bus(1'b0, STATUS_OFS, 32'h0);
            `CHK("bad dest", 1'b1, rd[ST_BAD_DEST_BIT])
            bus(1'b1, STATUS_OFS, 32'h4);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        t_reset();
        t_or();
        t_copy();
        t_ptr();
        t_indexed();
        t_move();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        complete_run();
    end
endmodule
